// ===== rtl/dmr_regs.vh
/*
 * Register map, field positions, reset values and command codes of the
 * dual receiver/transmitter control and status register bank.
 * Assumes: included by bare name from the rtl/ design files.
 */
`ifndef DMR_REGS_VH
`define DMR_REGS_VH

// word indices; byte address = 4 * index on the Avalon bus
`define DMR_IDX_MODE_A       4'h0
`define DMR_IDX_STATUS_A     4'h1
`define DMR_IDX_COMMAND_A    4'h2
`define DMR_IDX_AUX_CONTROL  4'h4
`define DMR_IDX_INT_STATUS   4'h5
`define DMR_IDX_CTR_UPPER    4'h6
`define DMR_IDX_CTR_LOWER    4'h7
`define DMR_IDX_MODE_B       4'h8
`define DMR_IDX_STATUS_B     4'h9
`define DMR_IDX_COMMAND_B    4'ha
`define DMR_IDX_SCRATCH      4'hc
`define DMR_IDX_PORT_CONFIG  4'hd
`define DMR_IDX_BITS_SET     4'he
`define DMR_IDX_BITS_CLEAR   4'hf
// own additions: input change status and output latch readback
`define DMR_IDX_INPUT_CHANGE 4'h3
`define DMR_IDX_OUT_LATCH    4'hb

// mode register 1 fields
`define DMR_M1_FLOW          7
`define DMR_M1_INT_SEL       6
`define DMR_M1_ERR_MODE      5
`define DMR_M1_PAR_HI        4
`define DMR_M1_PAR_LO        3
`define DMR_M1_PAR_TYPE      2
`define DMR_PAR_WITH         2'b00
`define DMR_PAR_FORCE        2'b01
`define DMR_PAR_NONE         2'b10
`define DMR_PAR_MULTIDROP    2'b11

// channel command: miscellaneous command in bits 6:4
`define DMR_CMD_SET_POINTER  3'h1
`define DMR_CMD_RESET_ERROR  3'h4

// aux control and port config fields
`define DMR_AUX_BRG_SET      7
`define DMR_CFG_OP4_INT      4
`define DMR_CFG_OP5_INT      5

// interrupt status bits
`define DMR_IS_RX_A          1
`define DMR_IS_RX_B          5
`define DMR_IS_PORT_CHANGE   7

`define DMR_RESET_BYTE       8'h00
`define DMR_READ_WAIT        2'h1

`endif

// ===== rtl/dmr_channel.v
/*
 * One channel's mode register 1, pointer, error status accumulation,
 * receive interrupt select and request-to-send flow control.
 * Assumes: receiver flags arrive synchronous to clock from the shifter.
 */
`timescale 1ns/10ps
`include "dmr_regs.vh"

module dmr_channel (
    input  wire       clock,
    input  wire       reset_n,
    input  wire       mode_access,
    input  wire       mode_write,
    input  wire [7:0] write_data,
    input  wire       set_pointer,
    input  wire       reset_error,
    input  wire       rx_start_bit,
    input  wire       receive_ready_flag,
    input  wire       receive_fifo_full_flag,
    input  wire       head_pop,
    input  wire [2:0] head_errors,
    input  wire       rts_latch_bit,
    output reg  [7:0] channel_mode_first,
    output reg  [7:0] channel_mode_second,
    output reg        pointer_second,
    output reg  [2:0] error_status,
    output wire       rx_int_source,
    output wire       rts_negated,
    output wire       parity_enable,
    output wire       multidrop,
    output wire       parity_odd
);
    reg rts_hold;

    // pointer and both mode registers
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            pointer_second      <= 1'b0;
            channel_mode_first  <= `DMR_RESET_BYTE;
            channel_mode_second <= `DMR_RESET_BYTE;
        end else begin
            if (set_pointer) begin
                pointer_second <= 1'b0;
            end else if (mode_access && !pointer_second) begin
                pointer_second <= 1'b1;
            end
            if (mode_access && mode_write && !pointer_second) begin
                channel_mode_first <= write_data;
            end
            if (mode_access && mode_write && pointer_second) begin
                channel_mode_second <= write_data;
            end
        end
    end

    // error status: head only, or sticky OR in block mode
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            error_status <= 3'h0;
        end else if (!channel_mode_first[`DMR_M1_ERR_MODE]) begin
            error_status <= head_errors;
        end else if (reset_error) begin
            // set wins: a head arriving now still counts
            error_status <= head_pop ? head_errors : 3'h0;
        end else if (head_pop) begin
            error_status <= error_status | head_errors;
        end
    end

    // flow control hold; released when a fifo slot frees up
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rts_hold <= 1'b0;
        end else if (!receive_fifo_full_flag) begin
            rts_hold <= 1'b0;
        end else if (channel_mode_first[`DMR_M1_FLOW] && rx_start_bit) begin
            rts_hold <= 1'b1;
        end
    end

    // latch bit is never touched here, only masked
    assign rts_negated   = !rts_latch_bit || rts_hold;
    assign rx_int_source = channel_mode_first[`DMR_M1_INT_SEL] ?
                           receive_fifo_full_flag :
                           receive_ready_flag;
    // with or forced parity both add and check a bit
    assign parity_enable = (channel_mode_first[4:3] == `DMR_PAR_WITH) ||
                           (channel_mode_first[4:3] == `DMR_PAR_FORCE);
    assign multidrop     = channel_mode_first[4:3] ==
                           `DMR_PAR_MULTIDROP;
    // type bit means odd/even, forced level or address flag level
    assign parity_odd    = (channel_mode_first[4:3] != `DMR_PAR_NONE) &&
                           channel_mode_first[`DMR_M1_PAR_TYPE];
endmodule // dmr_channel

// ===== rtl/dmr_top.v
/*
 * Control and status register bank of a dual asynchronous receiver/
 * transmitter: mode register 1 for both channels, output port latch with
 * bit set/clear, aux control, input change, interrupt status/mask,
 * counter preload and scratch, on an Avalon-MM slave with waitrequest.
 * Assumes: shifters, counter and baud logic sit outside and exchange
 * flags synchronous to clock.
 * Reads wait one cycle; writes never wait.
 */
// The Avalon-MM register port and the register offsets are this design's own decisions.
`timescale 1ns/10ps
`include "dmr_regs.vh"

module dmr_top (
    input  wire        clock,
    input  wire        rst_n,
    input  wire [3:0]  address,
    input  wire        read,
    input  wire        write,
    input  wire [31:0] writedata,
    output reg  [31:0] readdata,
    output wire        waitrequest,
    input  wire [1:0]  rx_start_bit,
    input  wire [1:0]  receive_ready_flag,
    input  wire [1:0]  receive_fifo_full_flag,
    input  wire [1:0]  head_pop,
    input  wire [5:0]  head_errors,
    input  wire [1:0]  transmit_ready_flag,
    input  wire [1:0]  delta_break,
    input  wire        counter_ready,
    input  wire [3:0]  input_pins,
    output wire [7:0]  output_pins,
    output wire        request_to_send_out_n,
    output wire        interrupt_request_n,
    output wire        baud_set_two,
    output wire [1:0]  parity_enable,
    output wire [1:0]  multidrop,
    output wire [1:0]  parity_odd,
    output reg  [15:0] counter_preload,
    output reg  [7:0]  command_out_a,
    output reg  [7:0]  command_out_b,
    output reg         command_valid_a,
    output reg         command_valid_b
);
    // reset copy
    reg         reset_meta;
    reg         reset_n;

    // written registers
    reg  [7:0]  output_port_latch;
    reg  [7:0]  output_port_config;
    reg  [7:0]  aux_control;
    reg  [7:0]  interrupt_mask;
    reg  [7:0]  scratch_pad;

    // input history
    reg  [3:0]  input_seen;
    reg  [3:0]  input_delta;

    // read path
    reg  [1:0]  read_wait;
    reg  [7:0]  next_latch;
    reg  [7:0]  read_byte;

    // status words
    wire [7:0]  interrupt_status;
    wire [7:0]  input_change_status;

    // channel results
    wire [1:0]  rx_int_source;
    wire [1:0]  rts_negated;
    wire [1:0]  pointer_second;
    wire [15:0] mode_first;
    wire [15:0] mode_second;
    wire [5:0]  error_status;

    // decode
    wire [3:0]  delta_now;
    wire        wr_cycle;
    wire        rd_done;
    wire        input_read;
    wire [1:0]  mode_hit;
    wire [1:0]  set_pointer;
    wire [1:0]  reset_error;
    wire [1:0]  command_hit;

    // reset release through two flops
    // only reset_n fans out
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            reset_meta <= 1'b0;
            reset_n    <= 1'b0;
        end else begin
            reset_meta <= 1'b1;
            reset_n    <= reset_meta;
        end
    end

    // writes finish at once; reads wait one cycle for registered data
    assign waitrequest = read && (read_wait != `DMR_READ_WAIT);
    assign wr_cycle    = write;

    // done where wait falls
    assign rd_done     = read && (read_wait == `DMR_READ_WAIT);

    // one waited cycle per read
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            read_wait <= 2'h0;
        end else if (read && read_wait != `DMR_READ_WAIT) begin
            read_wait <= read_wait + 2'h1;
        end else begin
            read_wait <= 2'h0;
        end
    end

    // a read hits in its last cycle
    assign mode_hit[0]    = (address == `DMR_IDX_MODE_A) &&
                            (wr_cycle || rd_done);
    assign mode_hit[1]    = (address == `DMR_IDX_MODE_B) &&
                            (wr_cycle || rd_done);
    assign command_hit[0] = wr_cycle && address == `DMR_IDX_COMMAND_A;
    assign command_hit[1] = wr_cycle && address == `DMR_IDX_COMMAND_B;
    assign input_read     = rd_done && address == `DMR_IDX_INPUT_CHANGE;

    // per-channel command decode and channel logic
    genvar ch;
    generate
        for (ch = 0; ch < 2; ch = ch + 1) begin : g_chan
            assign set_pointer[ch] = command_hit[ch] &&
                writedata[6:4] == `DMR_CMD_SET_POINTER;
            assign reset_error[ch] = command_hit[ch] &&
                writedata[6:4] == `DMR_CMD_RESET_ERROR;

            // A at 0, B at 1
            dmr_channel u_chan (
                .clock                  (clock),
                .reset_n                (reset_n),
                .mode_access            (mode_hit[ch]),
                .mode_write             (wr_cycle),
                .write_data             (writedata[7:0]),
                .set_pointer            (set_pointer[ch]),
                .reset_error            (reset_error[ch]),
                .rx_start_bit           (rx_start_bit[ch]),
                .receive_ready_flag     (receive_ready_flag[ch]),
                .receive_fifo_full_flag (receive_fifo_full_flag[ch]),
                .head_pop               (head_pop[ch]),
                .head_errors            (head_errors[3*ch+2:3*ch]),
                .rts_latch_bit          (output_port_latch[ch]),
                .channel_mode_first     (mode_first[8*ch+7:8*ch]),
                .channel_mode_second    (mode_second[8*ch+7:8*ch]),
                .pointer_second         (pointer_second[ch]),
                .error_status           (error_status[3*ch+2:3*ch]),
                .rx_int_source          (rx_int_source[ch]),
                .rts_negated            (rts_negated[ch]),
                .parity_enable          (parity_enable[ch]),
                .multidrop              (multidrop[ch]),
                .parity_odd             (parity_odd[ch])
            );
        end
    endgenerate

    // output latch: set then clear, one-hot per written bit
    always @* begin
        next_latch = output_port_latch;
        if (wr_cycle && address == `DMR_IDX_BITS_SET) begin
            next_latch = output_port_latch | writedata[7:0];
        end

        // separate indices, never both
        if (wr_cycle && address == `DMR_IDX_BITS_CLEAR) begin
            next_latch = output_port_latch & ~writedata[7:0];
        end
    end

    // software written control registers
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            output_port_latch  <= `DMR_RESET_BYTE;
            output_port_config <= `DMR_RESET_BYTE;
            aux_control        <= `DMR_RESET_BYTE;
            interrupt_mask     <= `DMR_RESET_BYTE;
            scratch_pad        <= `DMR_RESET_BYTE;
            counter_preload    <= 16'h0000;
            command_out_a      <= 8'h00;
            command_out_b      <= 8'h00;
            command_valid_a    <= 1'b0;
            command_valid_b    <= 1'b0;
        end else begin
            output_port_latch <= next_latch;

            // command valid pulse
            command_valid_a   <= command_hit[0];
            command_valid_b   <= command_hit[1];
            if (command_hit[0]) begin
                command_out_a <= writedata[7:0];
            end
            if (command_hit[1]) begin
                command_out_b <= writedata[7:0];
            end

            // unmapped writes fall through
            if (wr_cycle) begin
                case (address)
                    `DMR_IDX_PORT_CONFIG: begin
                        output_port_config <= writedata[7:0];
                    end
                    `DMR_IDX_AUX_CONTROL: begin
                        aux_control <= writedata[7:0];
                    end
                    `DMR_IDX_INT_STATUS: begin
                        interrupt_mask <= writedata[7:0];
                    end
                    `DMR_IDX_SCRATCH: begin
                        scratch_pad <= writedata[7:0];
                    end
                    `DMR_IDX_CTR_UPPER: begin
                        counter_preload[15:8] <= writedata[7:0];
                    end
                    `DMR_IDX_CTR_LOWER: begin
                        counter_preload[7:0] <= writedata[7:0];
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // input change tracking; new edge wins over read clear
    assign delta_now = input_pins ^ input_seen;
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            input_seen  <= 4'h0;
            input_delta <= 4'h0;
        end else begin
            input_seen  <= input_pins;
            // clear only reported flags
            input_delta <= (input_read ? input_delta & ~readdata[7:4] :
                            input_delta) | delta_now;
        end
    end
    // flags high, levels low
    assign input_change_status = {input_delta, input_seen};

    // port change needs its enable
    assign interrupt_status = {
        |(input_delta & aux_control[3:0]),
        delta_break[1],
        rx_int_source[1],
        transmit_ready_flag[1],
        counter_ready,
        delta_break[0],
        rx_int_source[0],
        transmit_ready_flag[0]};

    // level, not pulse
    assign interrupt_request_n = ~|(interrupt_status & interrupt_mask);
    assign baud_set_two        = aux_control[`DMR_AUX_BRG_SET];

    // pins inverted from latch; pin 0 = rts, 4/5 optional interrupt outs
    assign request_to_send_out_n = rts_negated[0];
    // flow hold over pins 0 and 1
    assign output_pins[0]   = rts_negated[0];
    assign output_pins[1]   = rts_negated[1];

    // plain latch pins
    assign output_pins[3:2] = ~output_port_latch[3:2];
    // interrupt pins are active low like the latch-driven pins
    assign output_pins[4]   = output_port_config[`DMR_CFG_OP4_INT] ?
                              ~rx_int_source[0] :
                              ~output_port_latch[4];

    // pin five: channel B
    assign output_pins[5]   = output_port_config[`DMR_CFG_OP5_INT] ?
                              ~rx_int_source[1] :
                              ~output_port_latch[5];

    // top pins plain too
    assign output_pins[7:6] = ~output_port_latch[7:6];

    // read mux; mode index follows the pointer
    always @* begin
        case (address)
            `DMR_IDX_MODE_A:
                read_byte = pointer_second[0] ? mode_second[7:0] :
                                                mode_first[7:0];
            `DMR_IDX_MODE_B:
                read_byte = pointer_second[1] ? mode_second[15:8] :
                                                mode_first[15:8];
            // error bits over flags
            `DMR_IDX_STATUS_A:
                read_byte = {error_status[2:0], 3'h0,
                             receive_fifo_full_flag[0],
                             receive_ready_flag[0]};
            `DMR_IDX_STATUS_B:
                read_byte = {error_status[5:3], 3'h0,
                             receive_fifo_full_flag[1],
                             receive_ready_flag[1]};

            // plain readback
            `DMR_IDX_INPUT_CHANGE: read_byte = input_change_status;
            `DMR_IDX_INT_STATUS:   read_byte = interrupt_status;
            `DMR_IDX_CTR_UPPER:    read_byte = counter_preload[15:8];
            `DMR_IDX_CTR_LOWER:    read_byte = counter_preload[7:0];
            `DMR_IDX_SCRATCH:      read_byte = scratch_pad;
            `DMR_IDX_OUT_LATCH:    read_byte = output_port_latch;
            default:               read_byte = 8'h00;
        endcase
    end

    // data registered in the waited cycle, stands at completion edge
    // late changes show next read
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            readdata <= 32'h00000000;
        end else if (read && read_wait != `DMR_READ_WAIT) begin
            readdata <= {24'h000000, read_byte};
        end
    end
endmodule // dmr_top

// ===== test/dmr_top_asserts.sv
/* checker: bus timing and output relations of dmr_top
   assumes: bound to dmr_top, sees only its ports */
`timescale 1ns/10ps
module dmr_top_chk (
    input wire        clock,
    input wire        rst_n,
    input wire [3:0]  address,
    input wire        read,
    input wire        write,
    input wire [31:0] writedata,
    input wire [31:0] readdata,
    input wire        waitrequest,
    input wire [7:0]  output_pins,
    input wire        request_to_send_out_n,
    input wire        interrupt_request_n,
    input wire        baud_set_two,
    input wire [15:0] counter_preload,
    input wire        command_valid_a
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    // writes are taken at once, reads stall one cycle
    a_write_no_wait: assert property (write |-> !waitrequest)
        else $error("write stalled");
    a_read_one_wait: assert property
        ($rose(read) |-> waitrequest ##1 !waitrequest)
        else $error("read wait not one cycle");
    a_data_holds: assert property (!read |=> $stable(readdata))
        else $error("read data moved without a read");
    // a cleared latch bit 0 negates rts whatever flow control does
    a_rts_pin_zero: assert property (
        write && address == 4'hf && writedata[0] |=>
        request_to_send_out_n && output_pins[0])
        else $error("rts not negated by latch clear");
    a_baud_set_follow: assert property (
        write && address == 4'h4 |=> baud_set_two == $past(writedata[7]))
        else $error("baud set select wrong");
    // pins 7:6 carry no special function, so the latch shows inverted
    a_set_bits_low: assert property (
        write && address == 4'he |=>
        (output_pins[7:6] & $past(writedata[7:6])) == 2'b00)
        else $error("set bit not driven low");
    a_clear_bits_high: assert property (
        write && address == 4'hf |=>
        (~output_pins[7:6] & $past(writedata[7:6])) == 2'b00)
        else $error("cleared bit not driven high");
    a_mask_off_quiet: assert property (
        write && address == 4'h5 && writedata[7:0] == 8'h00 |=>
        interrupt_request_n)
        else $error("interrupt with empty mask");
    a_preload_low: assert property (
        write && address == 4'h7 |=>
        counter_preload[7:0] == $past(writedata[7:0]))
        else $error("preload low byte wrong");
    a_cmd_has_cause: assert property (
        $rose(command_valid_a) |->
        $past(write) && $past(address) == 4'h2)
        else $error("command pulse without write");
endmodule // dmr_top_chk

bind dmr_top dmr_top_chk chk (.clock, .rst_n, .address, .read, .write,
    .writedata, .readdata, .waitrequest, .output_pins,
    .request_to_send_out_n, .interrupt_request_n, .baud_set_two,
    .counter_preload, .command_valid_a);

// ===== test/dmr_host.sv
/* host processor model: Avalon-MM master with waitrequest
   assumes: tasks are called from the bench, one at a time */
`timescale 1ns/10ps
module dmr_host (
    input  wire        clock,
    output reg  [3:0]  address,
    output reg         read,
    output reg         write,
    output reg  [31:0] writedata,
    input  wire [31:0] readdata,
    input  wire        waitrequest
);
    reg [31:0] last;
    initial begin
        address = 4'h0;
        read = 1'b0;
        write = 1'b0;
        writedata = 32'h0;
    end
    // the edge that sees waitrequest low ends the transfer; only the
    // bench watchdog limits the wait
    task hold;
        begin
            @(posedge clock);
            while (waitrequest !== 1'b0)
                @(posedge clock);
            last = readdata;
        end
    endtask
    // host never relies on reset while multidrop is set
    task wr(input [3:0] idx, input [7:0] d);
        begin
            @(posedge clock);
            address <= idx;
            writedata <= {24'h0, d};
            write <= 1'b1;
            hold();
            write <= 1'b0;
            writedata <= ~{24'h0, d}; // released bus shows junk
        end
    endtask
    task rd(input [3:0] idx, output [31:0] q);
        begin
            @(posedge clock);
            address <= idx;
            read <= 1'b1;
            hold();
            read <= 1'b0;
            address <= ~idx;
            q = last;
        end
    endtask
endmodule // dmr_host

// ===== test/tb_dmr_top.sv
/* bench for dmr_top: register bank checked against a bench model
   assumes: dmr_host drives the bus, flags are driven here */
`timescale 1ns/10ps
module tb_dmr_top;
    reg         clock, rst_n, ctr;
    reg  [1:0]  start, rdy, full, pop, txr, dbrk;
    reg  [5:0]  herr;
    reg  [3:0]  pins;
    wire [3:0]  address;
    wire        read, write, waitrequest, rts_n, irq_n, baud;
    wire [31:0] writedata, readdata;
    wire [7:0]  opins, cmd_a, cmd_b;
    wire [1:0]  par_en, mdrop, par_odd;
    wire [15:0] preload;
    reg  [31:0] q;
    reg  [7:0]  v, d, e, lat;
    reg  [2:0]  acc;
    integer     i, j, fail_count, num_checks;

    dmr_host host (.clock(clock), .address(address), .read(read),
        .write(write), .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest));
    dmr_top dut (.clock(clock), .rst_n(rst_n), .address(address),
        .read(read), .write(write), .writedata(writedata),
        .readdata(readdata), .waitrequest(waitrequest),
        .rx_start_bit(start), .receive_ready_flag(rdy),
        .receive_fifo_full_flag(full), .head_pop(pop),
        .head_errors(herr), .transmit_ready_flag(txr),
        .delta_break(dbrk), .counter_ready(ctr), .input_pins(pins),
        .output_pins(opins), .request_to_send_out_n(rts_n),
        .interrupt_request_n(irq_n), .baud_set_two(baud),
        .parity_enable(par_en), .multidrop(mdrop), .parity_odd(par_odd),
        .counter_preload(preload), .command_out_a(cmd_a),
        .command_out_b(cmd_b), .command_valid_a(), .command_valid_b());

    always #50 clock = ~clock;
    task check(input [31:0] seen, input [31:0] exp);
        begin
            num_checks = num_checks + 1;
            if (seen !== exp) begin
                fail_count = fail_count + 1;
                $display("Error at %0t: seen %h expected %h",
                         $time, seen, exp);
            end
        end
    endtask
    task stop_test;
        begin
            if (fail_count == 0 && num_checks > 0)
                $display("NO MISMATCHES");
            else
                $display("MISMATCHES SEEN");
            $finish;
        end
    endtask
    // third edge after release is the first one a request may use
    task do_reset;
        begin
            @(posedge clock) rst_n <= 1'b0;
            repeat (8) @(posedge clock);
            rst_n <= 1'b1;
            repeat (3) @(posedge clock);
        end
    endtask
    initial begin
        #2000000 fail_count = fail_count + 1;
        stop_test();
    end
    initial begin
        {clock, rst_n, ctr, start, rdy, full, pop, txr, dbrk} = 0;
        {herr, pins, fail_count, num_checks} = 0;
        d = $urandom(32'he1eb4e54);
        do_reset();
        @(negedge clock);
        check({opins, rts_n, irq_n, baud}, {8'hff, 3'b110});
        // every parity mode and type on both channels
        for (i = 0; i < 8; i = i + 1) begin
            v = {3'b000, i[2:0], 2'b11};
            host.wr(4'h2, 8'h10);
            host.wr(4'ha, 8'h10);
            host.wr(4'h0, v);
            host.wr(4'h8, v);
            host.rd(4'h0, q);
            check(q, 32'h0);
            host.wr(4'h2, 8'h10);
            host.rd(4'h0, q);
            check(q, {24'h0, v});
            check(cmd_a, 8'h10);
            check(cmd_b, 8'h10);
            check(par_en, {2{i < 4}});
            check(mdrop, {2{i > 5}});
            if (i < 4 || i > 5)
                check(par_odd, {2{i[0]}});
        end
        host.wr(4'h2, 8'h10);
        host.wr(4'ha, 8'h10);
        host.wr(4'h0, 8'h00); // leave multidrop before reset
        host.wr(4'h8, 8'h00);
        do_reset();
        host.wr(4'h0, 8'h05);
        host.wr(4'h2, 8'h10);
        host.rd(4'h0, q);
        check(q, 32'h05);
        lat = 8'h00;
        for (i = 0; i < 6; i = i + 1) begin
            d = $urandom;
            host.wr(i[0] ? 4'hf : 4'he, d);
            lat = i[0] ? lat & ~d : lat | d;
            host.rd(4'hb, q);
            check(q, {24'h0, lat});
            check({opins, rts_n}, {~lat, ~lat[0]});
        end
        // flow control: start bit with full fifo drops rts
        host.wr(4'he, 8'h01);
        host.wr(4'h2, 8'h10);
        host.wr(4'h0, 8'h80);
        @(posedge clock) {full[0], start[0]} <= 2'b11;
        @(posedge clock) start[0] <= 1'b0;
        @(negedge clock) check(rts_n, 1'b1);
        host.rd(4'hb, q);
        check(q[0], 1'b1);
        @(posedge clock) full[0] <= 1'b0;
        repeat (3) @(negedge clock);
        check(rts_n, 1'b0);
        // receive interrupt source, pin four, mask
        host.wr(4'hd, 8'h30);
        for (i = 0; i < 4; i = i + 1) begin
            host.wr(4'h2, 8'h10);
            host.wr(4'h0, {1'b0, i[0], 6'h0});
            d = $urandom;
            rdy <= {d[0], i[1]};
            full <= {d[1], ~i[1]};
            {txr, dbrk, ctr} <= d[6:2];
            host.wr(4'h5, 8'h02);
            e[0] = i[0] ? ~i[1] : i[1];
            host.rd(4'h5, q);
            check(q, {1'b0, d[4], d[0], d[6], d[2], d[3], e[0], d[5]});
            check(opins[4], !e[0]);
            check(opins[5], !d[0]);
            check(irq_n, !e[0]);
        end
        // input change flags and enables
        host.wr(4'h5, 8'h80);
        host.wr(4'h4, 8'h85);
        @(negedge clock) check(baud, 1'b1);
        @(posedge clock) pins <= 4'h2;
        repeat (4) @(posedge clock);
        host.rd(4'h5, q);
        check({q[7], irq_n}, 2'b01);
        host.rd(4'h3, q);
        check(q, 32'h22);
        host.rd(4'h3, q);
        check(q, 32'h02);
        @(posedge clock) pins <= 4'h6;
        repeat (4) @(posedge clock);
        host.rd(4'h5, q);
        check({q[7], irq_n}, 2'b10);
        host.rd(4'h3, q);
        check(q, 32'h46);
        // character then block error mode
        for (i = 0; i < 2; i = i + 1) begin
            host.wr(4'h2, 8'h10);
            host.wr(4'h0, {2'b00, i[0], 5'h0});
            host.wr(4'h2, 8'h40);
            acc = 3'b000;
            for (j = 0; j < 4; j = j + 1) begin
                d = $urandom;
                @(posedge clock) {pop[0], herr[2:0]} <= {1'b1, d[2:0]};
                @(posedge clock) pop[0] <= 1'b0;
                acc = i ? acc | d[2:0] : d[2:0];
                host.rd(4'h1, q);
                check(q[7:5], acc);
            end
        end
        host.wr(4'h2, 8'h45);
        @(negedge clock) check(cmd_a, 8'h45);
        host.rd(4'h1, q);
        check(q[7:5], 3'b000);
        // scratch and counter preload
        d = $urandom;
        host.wr(4'hc, d);
        host.wr(4'h6, ~d);
        host.wr(4'h7, d);
        host.rd(4'hc, q);
        check(q, {24'h0, d});
        check(preload, {~d, d});
        stop_test();
    end
endmodule // tb_dmr_top
